// ==== rtl/aisrp_pkg.sv ====
// constants, states and state record of the accelerometer serial slave port
package aisrp_pkg;

   // bus protocol figures
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h0F;   // fixed upper six bits 001111
   localparam logic [4:0] MCODE_HI      = 5'h01;   // master code 00001xxx
   localparam logic [3:0] LAST_BIT      = 4'h7;    // index of the eighth data bit
   localparam logic [3:0] ACK_SLOT      = 4'h8;    // ninth clock of a byte
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_STEP      = 4'h1;
   localparam logic [2:0] MSB_IDX       = 3'h7;

   // register pointer limits
   localparam logic [7:0] PTR_BUF_READ  = 8'h7F;
   localparam logic [7:0] PTR_TOP       = 8'hFF;
   localparam logic [7:0] PTR_STEP      = 8'h01;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;

   // synchroniser reset: scl, sda, addr pin, select pin idle high
   localparam int unsigned PIN_W        = 4;
   localparam logic [3:0]  PIN_RESET    = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_REGA = 3'h3,
      ST_WDAT = 3'h2,
      ST_RDAT = 3'h6,
      ST_SKIP = 3'h4
   } aisrp_state_e;

   typedef struct packed {
      aisrp_state_e st;
      logic [3:0]   cnt;
      logic [6:0]   sh;
      logic [7:0]   txd;
      logic [7:0]   ptr;
      logic [7:0]   wdata;
      logic         wr;
      logic         rd;
      logic         ack_go;
      logic         busy;
      logic         first;
      logic         hs;
      logic         addr_x;
      logic         en;
      logic         drive_low;
      logic         scl_q;
      logic         sda_q;
   } aisrp_top_s;

   localparam aisrp_top_s TOP_RESET = '{
      st:        ST_IDLE,
      cnt:       4'h0,
      sh:        7'h00,
      txd:       8'h00,
      ptr:       8'h00,
      wdata:     8'h00,
      wr:        1'b0,
      rd:        1'b0,
      ack_go:    1'b0,
      busy:      1'b0,
      first:     1'b0,
      hs:        1'b0,
      addr_x:    1'b0,
      en:        1'b0,
      drive_low: 1'b0,
      scl_q:     1'b1,
      sda_q:     1'b1
   };

endpackage

// ==== rtl/aisrp_sync.sv ====
// two-flop synchroniser for pin levels entering the system clock domain
module aisrp_sync #(
   parameter int unsigned   W       = 1,
   parameter logic [W-1:0]  RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } aisrp_sync_s;

   aisrp_sync_s r;
   aisrp_sync_s n;

   always_comb begin
      n    = r;
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{s1: RST_VAL, s2: RST_VAL};
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;

endmodule // aisrp_sync

// ==== rtl/aisrp_link_bit.sv ====
// data line sampled on each rising edge of the bus clock
module aisrp_link_bit (
   // bus clock
   input  wire logic scl,
   // data line level and captured bit
   input  wire logic sda,
   output logic      bit_q
);

   typedef struct packed {
      logic smp;
   } aisrp_link_s;

   aisrp_link_s r;
   aisrp_link_s n;

   // held stable for the whole clock period, read only after scl rise is synchronised
   always_comb begin
      n     = r;
      n.smp = sda;
   end

   always_ff @(posedge scl) begin
      r <= n;
   end

   assign bit_q = r.smp;

endmodule // aisrp_link_bit

// ==== rtl/aisrp_i2c_slave.sv ====
// two-wire slave port giving a bus master access to 8-bit device registers
module aisrp_i2c_slave (
   // system clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET,
   // bus clock pin, also the link clock
   input  wire logic       SCL,
   output logic            SCL_O,
   output logic            SCL_OE_N,
   // bus data pin
   input  wire logic       SERIAL_IN_OR_DATA_PIN_I,
   output logic            SERIAL_IN_OR_DATA_PIN_O,
   output logic            SERIAL_IN_OR_DATA_PIN_OE_N,
   // straps and mode pins
   input  wire logic       SERIAL_OUT_OR_ADDR_PIN,
   input  wire logic       INTERFACE_SELECT_N,
   input  wire logic       STARTUP_DONE,
   // register file access
   output logic [7:0]      REG_ADDR,
   output logic [7:0]      REG_WDATA,
   output logic            REG_WR,
   output logic            REG_RD,
   input  wire logic [7:0] REG_RDATA,
   // status
   output logic            BUS_BUSY,
   output logic            HS_MODE,
   output logic            I2C_ENABLED
);

   aisrp_pkg::aisrp_top_s r;
   aisrp_pkg::aisrp_top_s n;

   logic [3:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       addr_s;
   logic       sel_s;
   logic       link_bit;
   logic       start_ev;
   logic       stop_ev;
   logic       rise_ev;
   logic       fall_ev;

   // pointer step, halting at the buffer read address and the top
   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      logic [7:0] q;
      q = p;
      if (p != aisrp_pkg::PTR_BUF_READ && p != aisrp_pkg::PTR_TOP) begin
         q = p + aisrp_pkg::PTR_STEP;
      end
      return q;
   endfunction

   aisrp_sync #(
      .W       (aisrp_pkg::PIN_W),
      .RST_VAL (aisrp_pkg::PIN_RESET)
   ) u_sync (
      .clk (CLK),
      .rst (RESET),
      .d   ({SCL, SERIAL_IN_OR_DATA_PIN_I, SERIAL_OUT_OR_ADDR_PIN, INTERFACE_SELECT_N}),
      .q   (pins_s)
   );

   aisrp_link_bit u_link (
      .scl   (SCL),
      .sda   (SERIAL_IN_OR_DATA_PIN_I),
      .bit_q (link_bit)
   );

   assign scl_s  = pins_s[3];
   assign sda_s  = pins_s[2];
   assign addr_s = pins_s[1];
   assign sel_s  = pins_s[0];

   assign start_ev = r.scl_q & scl_s & r.sda_q & ~sda_s;
   assign stop_ev  = r.scl_q & scl_s & ~r.sda_q & sda_s;
   assign rise_ev  = ~r.scl_q & scl_s;
   assign fall_ev  = r.scl_q & ~scl_s;

   always_comb begin
      logic [7:0] byte_in;
      byte_in = {r.sh, link_bit};
      n       = r;
      n.wr    = 1'b0;
      n.rd    = 1'b0;
      n.scl_q = scl_s;
      n.sda_q = sda_s;
      n.en    = sel_s;
      if (r.rd) begin
         n.txd = REG_RDATA;
      end
      if (r.wr) begin
         n.ptr = next_ptr(r.ptr);
      end
      if (!r.en) begin
         n.st        = aisrp_pkg::ST_IDLE;
         n.busy      = 1'b0;
         n.hs        = 1'b0;
         n.ack_go    = 1'b0;
         n.drive_low = 1'b0;
      end else if (start_ev) begin
         n.first  = ~r.busy;
         n.busy   = 1'b1;
         n.st     = aisrp_pkg::ST_ADDR;
         n.cnt    = aisrp_pkg::CNT_ZERO;
         n.ack_go = 1'b0;
         n.addr_x = addr_s;
      end else if (stop_ev) begin
         n.busy      = 1'b0;
         n.hs        = 1'b0;
         n.st        = aisrp_pkg::ST_IDLE;
         n.ack_go    = 1'b0;
         n.drive_low = 1'b0;
      end else begin
         if (rise_ev && r.st != aisrp_pkg::ST_IDLE) begin
            if (r.cnt == aisrp_pkg::ACK_SLOT) begin
               n.cnt    = aisrp_pkg::CNT_ZERO;
               n.ack_go = 1'b0;
               // master's answer to a byte we sent
               if (r.st == aisrp_pkg::ST_RDAT && !r.ack_go) begin
                  if (!link_bit) begin
                     n.ptr = next_ptr(r.ptr);
                     n.rd  = 1'b1;
                  end else begin
                     n.st = aisrp_pkg::ST_SKIP;
                  end
               end
            end else begin
               n.sh  = byte_in[6:0];
               n.cnt = r.cnt + aisrp_pkg::CNT_STEP;
               if (r.cnt == aisrp_pkg::LAST_BIT) begin
                  case (r.st)
                     aisrp_pkg::ST_ADDR: begin
                        n.first = 1'b0;
                        if (r.first && byte_in[7:3] == aisrp_pkg::MCODE_HI) begin
                           n.hs = 1'b1;
                           n.st = aisrp_pkg::ST_SKIP;
                        end else if (byte_in[7:1] == {aisrp_pkg::SLAVE_ADDR_HI, r.addr_x}) begin
                           if (!STARTUP_DONE) begin
                              n.st = aisrp_pkg::ST_SKIP;
                           end else begin
                              n.ack_go = 1'b1;
                              if (byte_in[0]) begin
                                 n.st = aisrp_pkg::ST_RDAT;
                                 n.rd = 1'b1;
                              end else begin
                                 n.st = aisrp_pkg::ST_REGA;
                              end
                           end
                        end else begin
                           n.st = aisrp_pkg::ST_SKIP;
                        end
                     end
                     aisrp_pkg::ST_REGA: begin
                        n.ptr    = byte_in;
                        n.ack_go = 1'b1;
                        n.st     = aisrp_pkg::ST_WDAT;
                     end
                     aisrp_pkg::ST_WDAT: begin
                        n.wdata  = byte_in;
                        n.wr     = 1'b1;
                        n.ack_go = 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         // data line changes only while the clock is low
         if (fall_ev) begin
            if (r.cnt == aisrp_pkg::ACK_SLOT) begin
               n.drive_low = r.ack_go;
            end else if (r.st == aisrp_pkg::ST_RDAT) begin
               n.drive_low = ~r.txd[aisrp_pkg::MSB_IDX - r.cnt[2:0]];
            end else begin
               n.drive_low = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         r <= aisrp_pkg::TOP_RESET;
      end else begin
         r <= n;
      end
   end

   // clock line is never held: waits are absorbed by the register file
   assign SCL_O                      = r.drive_low & 1'b0;
   assign SCL_OE_N                   = ~(r.drive_low & 1'b0);
   assign SERIAL_IN_OR_DATA_PIN_O    = 1'b0;
   assign SERIAL_IN_OR_DATA_PIN_OE_N = ~r.drive_low;
   assign REG_ADDR                   = r.ptr;
   assign REG_WDATA                  = r.wdata;
   assign REG_WR                     = r.wr;
   assign REG_RD                     = r.rd;
   assign BUS_BUSY                   = r.busy;
   assign HS_MODE                    = r.hs;
   assign I2C_ENABLED                = r.en;

endmodule // aisrp_i2c_slave

// ==== verif/aisrp_checker.sv ====
// concurrent checks on the serial slave port pins
module aisrp_checker (
   // clock and reset
   input wire logic       CLK,
   input wire logic       RESET,
   // bus pins
   input wire logic       SCL,
   input wire logic       SCL_OE_N,
   input wire logic       SERIAL_IN_OR_DATA_PIN_I,
   input wire logic       SERIAL_IN_OR_DATA_PIN_OE_N,
   // mode pins and status
   input wire logic       INTERFACE_SELECT_N,
   input wire logic       I2C_ENABLED,
   input wire logic       BUS_BUSY,
   // register side
   input wire logic [7:0] REG_ADDR,
   input wire logic       REG_WR,
   input wire logic       REG_RD
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence s_ack_high;
      SCL && !SERIAL_IN_OR_DATA_PIN_OE_N;
   endsequence
   sequence s_start;
      $past(SCL) && SCL && $fell(SERIAL_IN_OR_DATA_PIN_I);
   endsequence
   sequence s_stop;
      $past(SCL) && SCL && $rose(SERIAL_IN_OR_DATA_PIN_I);
   endsequence

   a_no_stretch: assert property (SCL_OE_N)
      else $error("bus clock held low by the port");
   a_sel_follow: assert property ($stable(INTERFACE_SELECT_N) [*5] |->
      I2C_ENABLED == INTERFACE_SELECT_N) else $error("enable does not follow select");
   a_quiet_off: assert property (!I2C_ENABLED [*2] |->
      SERIAL_IN_OR_DATA_PIN_OE_N && !REG_WR) else $error("activity while disabled");
   a_busy_start: assert property (s_start ##0 I2C_ENABLED |-> ##[1:6] BUS_BUSY)
      else $error("start not seen as busy");
   a_busy_stop: assert property (s_stop |-> ##[1:6] !BUS_BUSY)
      else $error("stop not seen as free");
   a_ack_held: assert property (s_ack_high |=> !SCL || !SERIAL_IN_OR_DATA_PIN_OE_N)
      else $error("data released while clock high");
   a_wr_rd_excl: assert property (!(REG_WR && REG_RD))
      else $error("write and read strobes together");
   a_ptr_step: assert property (REG_WR && REG_ADDR != 8'h7F && REG_ADDR != 8'hFF |=>
      REG_ADDR == $past(REG_ADDR) + 8'h01) else $error("pointer did not advance");
   a_ptr_halt: assert property (REG_WR && (REG_ADDR == 8'h7F || REG_ADDR == 8'hFF)
      |=> $stable(REG_ADDR)) else $error("pointer crossed its limit");
endmodule // aisrp_checker

bind aisrp_i2c_slave aisrp_checker u_chk (.CLK, .RESET, .SCL, .SCL_OE_N,
   .SERIAL_IN_OR_DATA_PIN_I, .SERIAL_IN_OR_DATA_PIN_OE_N, .INTERFACE_SELECT_N,
   .I2C_ENABLED, .BUS_BUSY, .REG_ADDR, .REG_WR, .REG_RD);

// ==== verif/aisrp_master.sv ====
// bus master model driving clock and open-drain data
module aisrp_master (
   // bus pins
   output logic      scl,
   output logic      pull,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int H = 17 * 12;

   initial begin
      scl = 1'b1; // stands high outside frames
      pull = 1'b0;
   end

   task automatic start;
      #(H / 2) pull = 1'b0;
      #(H / 2) scl = 1'b1;
      #H pull = 1'b1;
      #H scl = 1'b0;
   endtask

   task automatic stop;
      #(H / 2) pull = 1'b1;
      #(H / 2) scl = 1'b1;
      #H pull = 1'b0;
      #H;
   endtask

   // eight bits msb first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [8:0] q);
      logic [8:0] v;
      v = {d, a};
      for (int i = 8; i >= 0; i--) begin
         #(H / 2) pull = !v[i]; // released or held for ack
         #(H / 2) scl = 1'b1;
         #H q[i] = sda;
         scl = 1'b0;
      end
   endtask
endmodule // aisrp_master

// ==== verif/testbench.sv ====
// self-checking bench for the serial slave port
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, apin, sel, sdone;
   logic [7:0]  regs [256];
   logic [7:0]  wd [3];
   logic [7:0]  model [256];
   logic [7:0]  areg;
   logic [8:0]  q;
   logic [15:0] wexp;
   logic [15:0] exp_q [$];
   int          err_count = 0;
   int          checked = 0;
   wire logic   scl, pull, oe_n, sda, wr, busy, hs, en;
   wire logic   scl_m, scl_o, scl_oe_n, sda_o;
   wire logic [7:0] ra, wdat;

   // open-drain lines with pull-ups
   assign sda = !pull && (oe_n || sda_o);
   assign scl = scl_m && (scl_oe_n || scl_o);

   aisrp_i2c_slave DUT (.CLK(clk), .RESET(rst), .SCL(scl), .SCL_O(scl_o),
      .SCL_OE_N(scl_oe_n), .SERIAL_IN_OR_DATA_PIN_I(sda), .SERIAL_IN_OR_DATA_PIN_O(sda_o),
      .SERIAL_IN_OR_DATA_PIN_OE_N(oe_n), .SERIAL_OUT_OR_ADDR_PIN(apin),
      .INTERFACE_SELECT_N(sel), .STARTUP_DONE(sdone), .REG_ADDR(ra),
      .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(), .REG_RDATA(regs[ra]),
      .BUS_BUSY(busy), .HS_MODE(hs), .I2C_ENABLED(en));
   aisrp_master m (.scl(scl_m), .pull(pull), .sda(sda));

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // expected pointer step, halting at the buffer read address and the top
   function automatic logic [7:0] nxt(input logic [7:0] a);
      return (a == 8'h7F || a == 8'hFF) ? a : a + 8'h01;
   endfunction

   task automatic adr(input logic rw);
      m.start();
      m.xbyte({aisrp_pkg::SLAVE_ADDR_HI, apin, rw}, 1'b1, q);
      chk("address ack", 16'h0000, 16'(q[0]));
   endtask

   task automatic wburst(input logic [7:0] a);
      adr(1'b0);
      chk("bus busy", 16'h0001, 16'(busy));
      m.xbyte(a, 1'b1, q);
      chk("register ack", 16'h0000, 16'(q[0]));
      for (int i = 0; i < 3; i++) begin
         wd[i] = 8'($urandom);
         exp_q.push_back({a, wd[i]});
         model[a] = wd[i];
         a = nxt(a);
         m.xbyte(wd[i], 1'b1, q);
         chk("data ack", 16'h0000, 16'(q[0]));
      end
      m.stop();
      chk("bus busy", 16'h0000, 16'(busy));
   endtask

   task automatic rburst(input logic [7:0] a);
      adr(1'b0);
      m.xbyte(a, 1'b1, q);
      chk("register ack", 16'h0000, 16'(q[0]));
      adr(1'b1);
      for (int i = 0; i < 3; i++) begin
         m.xbyte(8'hFF, i == 2, q);
         chk("read data", 16'(model[a]), 16'(q[8:1]));
         a = nxt(a);
      end
      m.stop();
   endtask

   // register file beside the port; writes checked in arrival order, mid-cycle
   always @(negedge clk) begin
      if (!rst && wr !== 1'b0) begin
         regs[ra] <= wdat;
         wexp = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
         chk("register write", wexp, {ra, wdat});
      end
   end

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // whole run is near 110 us
   initial begin
      #400_000;
      err_count++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      apin = 1'b0;
      sel = 1'b1;
      sdone = 1'b1;
      void'($urandom(21));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      for (int p = 0; p < 2; p++) begin
         @(negedge clk) apin = p[0];
         areg = p[0] ? {1'b0, 7'($urandom)} : 8'h7E; // register byte msb clear
         repeat (4) @(negedge clk);
         wburst(areg);
         rburst(areg);
      end
      // wrong address, startup pending, port deselected, master code
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         sdone = (k != 1);
         sel = (k != 2);
         repeat (6) @(negedge clk);
         m.start();
         m.xbyte(k == 3 ? {aisrp_pkg::MCODE_HI, 3'($urandom)} :
                 {aisrp_pkg::SLAVE_ADDR_HI, apin ^ (k == 0), 1'b0}, 1'b1, q);
         chk("refused ack", 16'h0001, 16'(q[0]));
         if (k == 3) chk("high speed", 16'h0001, 16'(hs));
         if (k == 2) chk("port enabled", 16'h0000, 16'(en));
         m.stop();
         chk("high speed", 16'h0000, 16'(hs));
      end
      chk("pending writes", 16'h0000, 16'(exp_q.size()));
      stop_test();
   end
endmodule // testbench
